/* File: rtl/bbseq_pkg.sv */
package bbseq_pkg;

   // ------------------------------------------------------------
   // Qualification and cool-down counts
   // ------------------------------------------------------------
   localparam int unsigned QUAL_CYCLES  = 1024;
   localparam int unsigned QUAL_W       = 11;
   localparam int unsigned COOL_CROSS   = 32;
   localparam int unsigned COOL_W       = 6;
   localparam int unsigned REPORT_BITS  = 8;

   // ------------------------------------------------------------
   // Enable decode levels
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      EN_SHUTDOWN,
      EN_STANDBY,
      EN_ACTIVE
   } en_level_e;

   // ------------------------------------------------------------
   // Timer sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TMR_IDLE,
      TMR_CHARGE,
      TMR_COOL_UP,
      TMR_COOL_DOWN
   } tmr_state_e;

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
   localparam logic [1:0]  HSIZE_WORD  = 2'h2;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

endpackage : bbseq_pkg

/* File: rtl/qual_counter.sv */
`timescale 1ns/1ps

// Counts consecutive cycles of a condition; clears when it goes false
module qual_counter
   import bbseq_pkg::*;
#(
   parameter int unsigned COUNT = QUAL_CYCLES
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Condition and result
   input  wire logic clr,
   input  wire logic cond,
   output logic      done
);

   logic [QUAL_W-1:0] cnt_r;
   logic [QUAL_W-1:0] cnt_nxt;

   assign cnt_nxt = (clr || !cond) ? '0 :
                    (done ? cnt_r : cnt_r + 1'b1);
   assign done    = (cnt_r == QUAL_W'(COUNT));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   property p_clear_on_false;
      @(posedge hclk) disable iff (!hresetn)
      !cond |=> (cnt_r == '0);
   endproperty
   a_clear_on_false: assert property (p_clear_on_false)
      else $error("qualification count not cleared");

endmodule : qual_counter

/* File: rtl/bbseq.sv */
`timescale 1ns/1ps

// Functional notes
// - Enable with first terminal undervoltage clear starts in buck mode unless force boost is set.
// - Enable with first terminal undervoltage tripped starts in boost mode.
// - Both terminal undervoltages tripped: buck, fault, soft-start low, no switching.
// - Buck goes boost on first undervoltage or qualified buck feedback overvoltage.
// - Boost goes buck on second undervoltage or qualified boost feedback overvoltage.
// - Both feedback overvoltages qualified together: buck and fault.
// - Either internal rail undervoltage forces buck and fault at once.
// - Fault output always coincides with switching stopped and soft-start pulled low.
// - Diagnostic states shift out active low, open drain, at sync rate.
// - Sync takes an external clock; static high enables spread spectrum.
// - In boost, regulation at limit plus switch drop starts timer charging.
// - Timer at top turns first protection switch off, begins cool-down.
// - Cool-down cycles timer; on 32nd downward crossing gate re-enables.
// - Enable level above threshold enables; below stops switching and switches off.
// - Enable far low turns off references: low-quiescent shutdown.
// - Second protect gate on after enable; off when disabled, faulted, negative.
// - First protect gate on after enable; off when disabled, faulted, negative.
// - Buck reverse current near equal terminals flags and opens first switch.
// - Mode line released in buck, pulled low in boost.
// - Forced boost with second undervoltage faults instead of changing mode.
module bbseq
   import bbseq_pkg::*;
#(
   parameter int unsigned QUAL_COUNT = QUAL_CYCLES,
   parameter int unsigned COOL_COUNT = COOL_CROSS
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Enable comparators
   input  wire logic        enable_above_on,
   input  wire logic        enable_above_ref,
   // Comparators
   input  wire logic        first_terminal_undervoltage,
   input  wire logic        second_terminal_undervoltage,
   input  wire logic        boost_feedback_input,
   input  wire logic        buck_feedback_input,
   input  wire logic        gate_drive_rail_uv,
   input  wire logic        internal_logic_rail_uv,
   input  wire logic        first_terminal_negative,
   input  wire logic        second_terminal_negative,
   input  wire logic        terminals_within_margin,
   input  wire logic        input_current_negative,
   input  wire logic        boost_output_current_set,
   input  wire logic        first_switch_drop_high,
   input  wire logic        soa_timer_high,
   input  wire logic        soa_timer_low,
   // Mode line (open drain) and sync
   input  wire logic        direction_select_line_in,
   output logic             direction_select_line_out,
   output logic             direction_select_line_oe,
   input  wire logic        sync_in,
   // Control outputs
   output logic             switching_enable,
   output logic             softstart_pull_low,
   output logic             first_protect_gate,
   output logic             second_protect_gate,
   output logic             soa_timer_charge,
   output logic             soa_timer_cool_charge,
   output logic             soa_timer_cool_discharge,
   output logic             regulators_enable,
   output logic             references_enable,
   output logic             spread_spectrum_enable,
   output logic             reverse_current_flag,
   // Open-drain status pins
   output logic             fault_n_out,
   output logic             fault_n_oe,
   output logic             report_n_out,
   output logic             report_n_oe
);

   // ------------------------------------------------------------
   // Enable decode
   // ------------------------------------------------------------
   en_level_e en_level;
   logic      enabled;
   logic      enabled_r;
   logic      enable_rise;

   assign en_level    = enable_above_on  ? EN_ACTIVE :
                        enable_above_ref ? EN_STANDBY : EN_SHUTDOWN;
   assign enabled     = (en_level == EN_ACTIVE);
   assign enable_rise = enabled && !enabled_r;
   assign regulators_enable = enabled;
   assign references_enable = (en_level != EN_SHUTDOWN);

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   // CTRL bit0: force boost (software drives mode line low); bit1: fault clear
   logic [31:0] ctrl_r;
   logic        wr_pend_r;
   logic        rd_pend_r;
   logic [7:0]  addr_r;
   logic [31:0] rdata_r;
   logic        bus_take;
   logic        force_boost;
   logic [31:0] status_word;
   logic        fault_clear;

   // Write-one clear of a latched fault; the bit is not stored
   assign fault_clear = wr_pend_r && (addr_r == REG_CTRL) && hwdata[1];
   assign bus_take  = hsel && hready && (htrans == HTRANS_NSEQ);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_r;
   assign force_boost = ctrl_r[0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= '0;
      end else begin
         wr_pend_r <= bus_take && hwrite;
         rd_pend_r <= bus_take && !hwrite;
         addr_r    <= bus_take ? haddr : addr_r;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_pend_r && addr_r == REG_CTRL) begin
         ctrl_r <= {30'h0, 1'b0, hwdata[0]};
      end
   end

   // Read data registered at address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= '0;
      end else if (bus_take && !hwrite) begin
         rdata_r <= (haddr == REG_CTRL)   ? ctrl_r :
                    (haddr == REG_STATUS) ? status_word : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Mode and fault
   // ------------------------------------------------------------
   logic boost_r;
   logic boost_nxt;
   logic fault_r;
   logic fault_nxt;
   logic fb2_ov_q;
   logic fb1_ov_q;
   logic both_ov_q;
   logic rail_uv;
   logic forced_low;

   qual_counter #(.COUNT(QUAL_COUNT)) u_q_buck (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clr     (!enabled),
      .cond    (buck_feedback_input && !boost_feedback_input),
      .done    (fb2_ov_q)
   );
   qual_counter #(.COUNT(QUAL_COUNT)) u_q_boost (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clr     (!enabled),
      .cond    (boost_feedback_input && !buck_feedback_input),
      .done    (fb1_ov_q)
   );
   qual_counter #(.COUNT(QUAL_COUNT)) u_q_both (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clr     (!enabled),
      .cond    (boost_feedback_input && buck_feedback_input),
      .done    (both_ov_q)
   );

   assign rail_uv    = gate_drive_rail_uv || internal_logic_rail_uv;
   assign forced_low = force_boost || (!direction_select_line_in && !boost_r);

   always_comb begin
      boost_nxt = boost_r;
      fault_nxt = fault_r;
      if (!enabled) begin
         boost_nxt = 1'b0;
         fault_nxt = 1'b0;
      end else if (rail_uv || both_ov_q ||
                   (first_terminal_undervoltage && second_terminal_undervoltage)) begin
         boost_nxt = 1'b0;
         fault_nxt = 1'b1;
      end else if (enable_rise) begin
         boost_nxt = first_terminal_undervoltage || force_boost;
      end else if (fault_r) begin
         // A standing rail undervoltage, dual feedback overvoltage or dual terminal undervoltage is taken above, so its set wins over a clear
         fault_nxt = !fault_clear;
      end else if (!boost_r) begin
         boost_nxt = first_terminal_undervoltage || fb2_ov_q || forced_low;
      end else if (second_terminal_undervoltage && forced_low) begin
         fault_nxt = 1'b1;
      end else if (second_terminal_undervoltage || fb1_ov_q) begin
         boost_nxt = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         boost_r   <= 1'b0;
         fault_r   <= 1'b0;
         enabled_r <= 1'b0;
      end else begin
         boost_r   <= boost_nxt;
         fault_r   <= fault_nxt;
         enabled_r <= enabled;
      end
   end

   assign switching_enable   = enabled && !fault_r;
   assign softstart_pull_low = !switching_enable;
   assign fault_n_out        = 1'b0;
   assign fault_n_oe         = fault_r;

   assign direction_select_line_out = 1'b0;
   assign direction_select_line_oe  = boost_r;

   // ------------------------------------------------------------
   // Timer sequencer for the first protection switch
   // ------------------------------------------------------------
   tmr_state_e       tmr_r;
   tmr_state_e       tmr_nxt;
   logic [COOL_W-1:0] cool_r;
   logic [COOL_W-1:0] cool_nxt;

   always_comb begin
      tmr_nxt  = tmr_r;
      cool_nxt = cool_r;
      case (tmr_r)
         TMR_IDLE: begin
            if (boost_r && boost_output_current_set && first_switch_drop_high)
               tmr_nxt = TMR_CHARGE;
         end
         TMR_CHARGE: begin
            if (soa_timer_high) begin
               tmr_nxt  = TMR_COOL_DOWN;
               cool_nxt = '0;
            end else if (!(boost_output_current_set && first_switch_drop_high))
               tmr_nxt = TMR_IDLE;
         end
         TMR_COOL_DOWN: begin
            if (soa_timer_low) begin
               cool_nxt = cool_r + 1'b1;
               tmr_nxt  = (cool_r + 1'b1 == COOL_W'(COOL_COUNT)) ? TMR_IDLE : TMR_COOL_UP;
            end
         end
         TMR_COOL_UP: begin
            if (soa_timer_high)
               tmr_nxt = TMR_COOL_DOWN;
         end
         default: tmr_nxt = TMR_IDLE;
      endcase
      if (!enabled || !boost_r && tmr_r == TMR_CHARGE) begin
         tmr_nxt  = TMR_IDLE;
         cool_nxt = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmr_r  <= TMR_IDLE;
         cool_r <= '0;
      end else begin
         tmr_r  <= tmr_nxt;
         cool_r <= cool_nxt;
      end
   end

   assign soa_timer_charge         = (tmr_r == TMR_CHARGE);
   assign soa_timer_cool_charge    = (tmr_r == TMR_COOL_UP);
   assign soa_timer_cool_discharge = (tmr_r == TMR_COOL_DOWN);

   // ------------------------------------------------------------
   // Protection gates
   // ------------------------------------------------------------
   logic cooling;

   assign cooling = (tmr_r == TMR_COOL_UP) || (tmr_r == TMR_COOL_DOWN);
   assign reverse_current_flag = enabled && !boost_r && terminals_within_margin &&
                                 input_current_negative;
   assign first_protect_gate  = enabled && !fault_r && !first_terminal_negative &&
                                !cooling && !reverse_current_flag;
   assign second_protect_gate = enabled && !fault_r && !second_terminal_negative;

   // ------------------------------------------------------------
   // Sync and report stream
   // ------------------------------------------------------------
   logic                   sync_r;
   logic                   sync_edge;
   logic                   sync_static;
   logic [REPORT_BITS-1:0] rep_r;
   logic [2:0]             rep_idx_r;
   logic [REPORT_BITS-1:0] diag;

   assign diag = {rail_uv, boost_r, fault_r, cooling, reverse_current_flag,
                  second_terminal_undervoltage, first_terminal_undervoltage, enabled};
   assign sync_edge = sync_in && !sync_r;

   // Static high spreads
   // A high held through a full window counts as static; a sync clock whose
   // high phase outlasts the window would be taken for a static level
   qual_counter #(.COUNT(QUAL_COUNT)) u_q_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clr     (1'b0),
      .cond    (sync_in),
      .done    (sync_static)
   );
   assign spread_spectrum_enable = sync_static;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_r      <= 1'b0;
         rep_r       <= '0;
         rep_idx_r   <= '0;
      end else begin
         sync_r      <= sync_in;
         if (sync_edge) begin
            rep_idx_r <= rep_idx_r + 1'b1;
            rep_r     <= (rep_idx_r == '0) ? diag : {1'b0, rep_r[REPORT_BITS-1:1]};
         end
      end
   end

   assign report_n_out = 1'b0;
   assign report_n_oe  = rep_r[0];
   assign status_word  = {16'h0, diag, 4'h0, tmr_r, boost_r, fault_r};

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_fault_halts;
      @(posedge hclk) disable iff (!hresetn)
      fault_n_oe |-> !switching_enable && softstart_pull_low;
   endproperty
   a_fault_halts: assert property (p_fault_halts)
      else $error("fault without halt");

   property p_rail_uv;
      @(posedge hclk) disable iff (!hresetn)
      enabled && rail_uv ##1 enabled |-> fault_r && !boost_r;
   endproperty
   a_rail_uv: assert property (p_rail_uv)
      else $error("rail undervoltage not faulted");

   property p_disable_reset;
      @(posedge hclk) disable iff (!hresetn)
      !enabled |=> !fault_r && !boost_r;
   endproperty
   a_disable_reset: assert property (p_disable_reset)
      else $error("disable did not reset mode");

   property p_mode_line;
      @(posedge hclk) disable iff (!hresetn)
      direction_select_line_oe == boost_r;
   endproperty
   a_mode_line: assert property (p_mode_line)
      else $error("mode line drive mismatch");

   property p_gate2_off;
      @(posedge hclk) disable iff (!hresetn)
      (!enabled || fault_r || second_terminal_negative) |-> !second_protect_gate;
   endproperty
   a_gate2_off: assert property (p_gate2_off)
      else $error("second gate on when off required");

   property p_gate1_off;
      @(posedge hclk) disable iff (!hresetn)
      (!enabled || fault_r || first_terminal_negative) |-> !first_protect_gate;
   endproperty
   a_gate1_off: assert property (p_gate1_off)
      else $error("first gate on when off required");

   property p_rev_cur;
      @(posedge hclk) disable iff (!hresetn)
      reverse_current_flag |-> !boost_r && !first_protect_gate;
   endproperty
   a_rev_cur: assert property (p_rev_cur)
      else $error("reverse current not blocked");

   property p_timer_trip;
      @(posedge hclk) disable iff (!hresetn)
      enabled && boost_r && soa_timer_charge && soa_timer_high
         ##1 enabled |-> !first_protect_gate;
   endproperty
   a_timer_trip: assert property (p_timer_trip)
      else $error("timer trip did not open switch");

   property p_both_uv;
      @(posedge hclk) disable iff (!hresetn)
      enabled && !rail_uv && first_terminal_undervoltage && second_terminal_undervoltage
         ##1 enabled |-> fault_n_oe;
   endproperty
   a_both_uv: assert property (p_both_uv)
      else $error("both undervoltage not faulted");

   c_boost: cover property (@(posedge hclk) disable iff (!hresetn) $rose(boost_r));
   c_fault: cover property (@(posedge hclk) disable iff (!hresetn) $rose(fault_r));
   c_cool:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(cooling));
   c_rev:   cover property (@(posedge hclk) disable iff (!hresetn) reverse_current_flag);

endmodule : bbseq

/* File: verif/bbseq_partner.sv */
`timescale 1ns/1ps

// Stand-in for the timer capacitor with its comparators, and the mode line pull-up
module bbseq_partner (
   // Clock
   input  wire logic hclk,
   // Timer node
   input  wire logic charge,
   input  wire logic cool_up,
   input  wire logic cool_down,
   output logic      timer_high,
   output logic      timer_low,
   // Mode line
   input  wire logic line_oe,
   output logic      line_in
);
   int lvl = 0;

   // ------------------------------------------------------------
   // Timer node, one step per clock
   // ------------------------------------------------------------
   // ramp between levels
   always @(posedge hclk) begin
      if ((charge || cool_up) && lvl < 14)
         lvl <= lvl + 1;
      else if (lvl > 0)
         lvl <= lvl - 1;
   end
   assign timer_high = (lvl >= 14);
   assign timer_low  = (lvl <= 4);

   assign line_in = !line_oe;
endmodule : bbseq_partner

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_top
   import bbseq_pkg::*;
;
   localparam int QN = 8;
   localparam int CN = 4;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   // Comparator bits: uv1 uv2 fb1 fb2 rail_a rail_b neg1 neg2 near curneg iset drop
   logic [11:0] cmp;
   logic        en_on, en_ref, t_hi, t_lo, line_in, line_oe, sync_in, rep_out;
   logic        sw_en, ss_low, gate1, gate2, t_chg, t_up, t_dn, reg_en, ref_en, spread, rev;
   logic        flt_oe, rep_oe;
   logic [31:0] seed = 32'h2118;
   int          mismatches = 0;
   int          n_tests = 0;
   int          m_boost, m_fault, i, n, prev;

   assign hready = hreadyout;

   bbseq #(.QUAL_COUNT(QN), .COOL_COUNT(CN)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .enable_above_on(en_on), .enable_above_ref(en_ref),
      .first_terminal_undervoltage(cmp[0]), .second_terminal_undervoltage(cmp[1]),
      .boost_feedback_input(cmp[2]), .buck_feedback_input(cmp[3]),
      .gate_drive_rail_uv(cmp[4]), .internal_logic_rail_uv(cmp[5]),
      .first_terminal_negative(cmp[6]), .second_terminal_negative(cmp[7]),
      .terminals_within_margin(cmp[8]), .input_current_negative(cmp[9]),
      .boost_output_current_set(cmp[10]), .first_switch_drop_high(cmp[11]),
      .soa_timer_high(t_hi), .soa_timer_low(t_lo), .direction_select_line_in(line_in),
      .direction_select_line_out(), .direction_select_line_oe(line_oe), .sync_in(sync_in),
      .switching_enable(sw_en), .softstart_pull_low(ss_low), .first_protect_gate(gate1),
      .second_protect_gate(gate2), .soa_timer_charge(t_chg), .soa_timer_cool_charge(t_up),
      .soa_timer_cool_discharge(t_dn), .regulators_enable(reg_en), .references_enable(ref_en),
      .spread_spectrum_enable(spread), .reverse_current_flag(rev), .fault_n_out(),
      .fault_n_oe(flt_oe), .report_n_out(rep_out), .report_n_oe(rep_oe)
   );

   bbseq_partner far_u (.hclk(hclk), .charge(t_chg), .cool_up(t_up), .cool_down(t_dn),
      .timer_high(t_hi), .timer_low(t_lo), .line_oe(line_oe), .line_in(line_in));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask : cyc

   task automatic summarize();
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // Single word transfer; waits on ready rather than assuming zero wait states
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NSEQ;
      hwrite <= w;
      hsize <= {1'b0, HSIZE_WORD};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK(hresp, 1'b0)
   endtask : ahb

   // Model outputs follow mode, fault, enable decode and comparator levels
   task automatic chk();
      logic en;
      logic rv;
      en = en_on & en_ref;
      rv = (m_boost == 0) & cmp[8] & cmp[9];
      `CHK(line_oe, 1'(m_boost))
      `CHK(flt_oe, 1'(m_fault))
      `CHK(ss_low, !(en & (m_fault == 0)))
      `CHK(sw_en, en & (m_fault == 0))
      `CHK(gate2, en & (m_fault == 0) & !cmp[7])
      `CHK(gate1, en & (m_fault == 0) & !cmp[6] & !rv)
      `CHK(rev, rv)
      `CHK(reg_en, en)
      `CHK(ref_en, en_ref)
   endtask : chk

   task automatic step(input logic [11:0] v, input int k, input int b, input int f);
      cmp <= v;
      cyc(k);
      m_boost = b;
      m_fault = f;
      chk();
      cmp <= '0;
      cyc(2);
   endtask : step

   task automatic reenable();
      en_on <= 1'b0;
      cyc(3);
      m_boost = 0;
      m_fault = 0;
      chk();
      en_on <= 1'b1;
      cyc(3);
      chk();
   endtask : reenable

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      {hsel, hwrite, en_on, en_ref, sync_in} = '0;
      {haddr, htrans, hsize, hwdata, cmp} = '0;
      {m_boost, m_fault} = '0;
      hresetn = 1'b0;
      cyc(2);
      hresetn <= 1'b1;
      cyc(2);
      chk();
      en_ref <= 1'b1;
      cyc(3);
      chk();
      en_on <= 1'b1;
      cyc(3);
      chk();
      n = 2 + int'(rnd() % 4);
      step(12'h008, n, 0, 0);
      step(12'h008, n, 0, 0);
      step(12'h008, QN + 4, 1, 0);
      step(12'h002, 3, 0, 0);
      step(12'h001, 3, 1, 0);
      step(12'h004, QN + 4, 0, 0);
      step(12'h00c, QN + 4, 0, 1);
      reenable();
      cmp <= 12'h001;
      en_on <= 1'b0;
      cyc(3);
      en_on <= 1'b1;
      cyc(3);
      m_boost = 1;
      chk();
      cmp <= 12'hc01;
      cyc(3);
      `CHK(t_chg, 1'b1)
      for (i = 0; i < 100 && gate1 === 1'b1; i++) cyc(1);
      `CHK(gate1, 1'b0)
      n = 0;
      prev = 0;
      for (i = 0; i < 2000 && gate1 !== 1'b1; i++) begin
         cyc(1);
         if (t_lo === 1'b1 && prev == 0) n++;
         prev = (t_lo === 1'b1);
      end
      `CHK(n, CN)
      cmp <= '0;
      reenable();
      step(12'h003, 3, 0, 1);
      reenable();
      step(12'h010, 2, 0, 1);
      ahb(1'b1, REG_CTRL, 32'h2);
      cyc(2);
      m_fault = 0;
      chk();
      step(12'h020, 2, 0, 1);
      reenable();
      ahb(1'b0, REG_CTRL, 32'h0);
      `CHK(rd, CTRL_RESET)
      ahb(1'b1, REG_CTRL, 32'h1);
      step(12'h002, 3, 1, 1);
      ahb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd[1:0], 2'h3)
      ahb(1'b1, 8'h20, rnd());
      ahb(1'b0, 8'h20, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1'b1, REG_CTRL, 32'h0);
      reenable();
      step(12'h040, 2, 0, 0);
      step(12'h080, 2, 0, 0);
      step(12'h300, 3, 0, 0);
      sync_in <= 1'b1;
      n = 1;
      cyc(QN + 2);
      `CHK(spread, 1'b1)
      sync_in <= 1'b0;
      cyc(4);
      `CHK(spread, 1'b0)
      // sync near 250 kHz, half period of 400 clocks
      // idle enabled frame holds only the enable bit, sent low bit first
      repeat (16) begin
         if (!sync_in) n++;
         sync_in <= ~sync_in;
         cyc(400);
         `CHK(rep_out, 1'b0)
         `CHK(rep_oe, 1'(8'h01 >> ((n - 1) % 8)))
      end
      summarize();
   end

   initial begin
      cyc(40000);
      mismatches++;
      summarize();
   end
endmodule : tb_top
